// >>> ustws_slave.sv
// Summary of operation
// R1: three-wire slave, positive edge, overflow ends transfer
// R2: no slew limiting, no input noise filter; the code takes a pin level only after two synchronised samples agree
// R3: master makes the clock; slave only stretches
// R4: two-wire data output changes on falling edge
// R5: master checks clock really released after rising
// R6: every bus clock edge counts the counter
// R7: SDA low from bit 7 or port, direction set
// R8: start condition sets the start flag
// R9: after start, hold SCL low from falling edge
// R10: shift SDA in on rising SCL edge
// R11: overflow after eight bits forces SCL low
// R12: unaddressed slave releases SCL, awaits start
// R13: addressed slave acks, counter preloaded with 14
// R14: read direction means the slave drives SDA
// R15: bytes continue one direction until stop/start
// R16: full slave withholds acknowledge of last byte
// R17: SDA delayed 50 to 300 ns for detector
// R18: start detector works only in two-wire mode
// R19: start detection needs no shift clock source
// R20: external clock counts both edges
// R21: overflow pulse chains to timer 0
// R22: writing one clears start flag, releases hold
// R23: overflow flag set on wrap 15 to 0
// R24: stop sets stop flag, cleared by one
// R25: SCL and SDA synchronised before edge detection
module ustws_slave #(
    parameter int SDA_DLY = ustws_pkg::SDA_DLY_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [1:0] i_wire_mode,
    input wire logic [1:0] i_clock_sel,
    input wire logic i_clk_strobe,
    input wire logic i_t0_match,
    input wire logic i_sr_wr,
    input wire logic [ustws_pkg::SR_W-1:0] i_sr_wdata,
    input wire logic i_cnt_wr,
    input wire logic [ustws_pkg::CNT_W-1:0] i_cnt_wdata,
    input wire logic i_clr_start,
    input wire logic i_clr_ovf,
    input wire logic i_clr_stop,
    input wire logic i_sda_port,
    input wire logic i_sda_dir,
    input wire logic i_scl_port,
    input wire logic i_scl_dir,
    input wire logic i_do_dir,
    input wire logic i_sda_in,
    input wire logic i_scl_in,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    output logic o_scl_out,
    output logic o_scl_oe_n,
    output logic o_do_out,
    output logic o_do_oe_n,
    output logic [ustws_pkg::SR_W-1:0] o_shift_reg,
    output logic [ustws_pkg::CNT_W-1:0] o_count,
    output logic o_start_flag,
    output logic o_ovf_flag,
    output logic o_stop_flag,
    output logic o_collision,
    output logic o_ovf_pulse
);
    import ustws_pkg::*;

    logic rst_s1_q;
    logic rst_n_q;
    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic scl_q;
    logic sda_q;
    logic [SDA_DLY:0] sda_pipe_q;
    logic [SR_W-1:0] sr_q;
    logic [CNT_W-1:0] cnt_q;
    logic start_flag_q;
    logic ovf_flag_q;
    logic stop_flag_q;
    logic start_hold_q;
    logic latch_q;
    logic col_q;
    logic ovf_pulse_q;
    logic two_wire;
    logic scl_rise;
    logic scl_fall;
    logic sda_dly;
    logic start_det;
    logic stop_det;
    logic cnt_tick;
    logic shift_tick;
    logic cnt_wrap;
    logic scl_hold;
    logic sda_low;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // sync plus filter: a pin level is taken only after two synchronised samples agree
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], i_scl_in}; // [R25] [R2]
            sda_s_q <= {sda_s_q[1:0], i_sda_in}; // [R25]
            if (scl_s_q[1] == scl_s_q[2]) begin
                scl_q <= scl_s_q[2];
            end
            if (sda_s_q[1] == sda_s_q[2]) begin
                sda_q <= sda_s_q[2];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sda_pipe_q <= '1;
        end else begin
            sda_pipe_q <= {sda_pipe_q[SDA_DLY-1:0], sda_q}; // [R17]
        end
    end

    assign two_wire = i_wire_mode[1];
    assign scl_rise = (scl_s_q[2] == scl_s_q[1]) && scl_s_q[2] && !scl_q;
    assign scl_fall = (scl_s_q[2] == scl_s_q[1]) && !scl_s_q[2] && scl_q;
    assign sda_dly = sda_pipe_q[SDA_DLY-1];
    // detector looks only at the wire mode and the pins, not at the shift clock choice
    assign start_det = two_wire && scl_q && sda_pipe_q[SDA_DLY] && !sda_dly; // [R18] [R19]
    assign stop_det = two_wire && scl_q && !sda_pipe_q[SDA_DLY] && sda_dly;

    always_comb begin
        unique case (i_clock_sel)
            CS_SW: begin
                cnt_tick = i_clk_strobe;
                shift_tick = i_clk_strobe;
            end
            CS_T0: begin
                cnt_tick = i_t0_match;
                shift_tick = i_t0_match;
            end
            CS_EXT_POS: begin
                cnt_tick = scl_rise || scl_fall; // [R6] [R20]
                shift_tick = scl_rise; // [R10] [R1]
            end
            CS_EXT_NEG: begin
                cnt_tick = scl_rise || scl_fall; // [R20]
                shift_tick = scl_fall;
            end
        endcase
    end

    assign cnt_wrap = cnt_tick && !i_cnt_wr && (cnt_q == CNT_MAX); // [R23]

    // a software write in the same cycle as a clock wins
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sr_q <= SR_RST;
        end else if (i_sr_wr) begin
            sr_q <= i_sr_wdata;
        end else if (shift_tick) begin
            sr_q <= {sr_q[SR_W-2:0], sda_q}; // [R10]
        end
    end

    // preload of 14 before the ack gives a hold after the ack
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q <= CNT_RST;
        end else if (i_cnt_wr) begin
            cnt_q <= i_cnt_wdata; // [R13]
        end else if (cnt_tick) begin
            cnt_q <= cnt_q + 4'h1; // [R6]
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ovf_flag_q <= 1'b0;
            ovf_pulse_q <= 1'b0;
        end else begin
            ovf_pulse_q <= cnt_wrap; // [R21]
            if (cnt_wrap) begin
                ovf_flag_q <= 1'b1; // [R23] [R1] [R11]
            end else if (i_clr_ovf) begin
                ovf_flag_q <= 1'b0; // [R12]
            end
        end
    end

    // outside two-wire the start flag marks counter increments
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            start_flag_q <= 1'b0;
        end else if (start_det || (!two_wire && cnt_tick)) begin
            start_flag_q <= 1'b1; // [R8]
        end else if (i_clr_start) begin
            start_flag_q <= 1'b0; // [R22]
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stop_flag_q <= 1'b0;
        end else if (stop_det) begin
            stop_flag_q <= 1'b1; // [R24]
        end else if (i_clr_stop) begin
            stop_flag_q <= 1'b0; // [R24]
        end
    end

    // hold begins on the first falling SCL edge after the start
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            start_hold_q <= 1'b0;
        end else if (!two_wire || (i_clr_start && !start_det)) begin
            start_hold_q <= 1'b0; // [R22]
        end else if (start_flag_q && scl_fall) begin
            start_hold_q <= 1'b1; // [R9]
        end
    end

    // output latch: open while the clock rests at its non-sampling level, so an ack
    // written during a hold reaches the pin before the master releases the clock
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            latch_q <= 1'b1;
        end else if (!i_clock_sel[1]) begin
            latch_q <= sr_q[SR_MSB];
        end else if (i_clock_sel[0] ? (scl_rise || scl_q) : (scl_fall || !scl_q)) begin
            latch_q <= sr_q[SR_MSB]; // [R4]
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            col_q <= 1'b0;
        end else begin
            col_q <= two_wire && (sr_q[SR_MSB] != sda_q);
        end
    end

    // in two-wire mode the slave never drives SCL high; the master must see it rise
    assign scl_hold = two_wire && (start_hold_q ||
                      ((i_wire_mode == WM_TWO_HOLD) && ovf_flag_q)); // [R3] [R5] [R11]
    // a one in bit 7, with the SDA port bit high, leaves SDA free, which is how the ack is withheld
    assign sda_low = i_sda_dir && (!latch_q || !i_sda_port); // [R7] [R14] [R16]

    always_comb begin
        if (two_wire) begin
            o_sda_out = 1'b0;
            o_sda_oe_n = !sda_low; // [R13] [R15]
            o_scl_out = 1'b0;
            o_scl_oe_n = !(scl_hold || (i_scl_dir && !i_scl_port)); // [R9]
        end else begin
            o_sda_out = i_sda_port;
            o_sda_oe_n = !i_sda_dir;
            o_scl_out = i_scl_port;
            o_scl_oe_n = !i_scl_dir;
        end
    end

    assign o_do_out = latch_q;
    assign o_do_oe_n = !(i_do_dir && (i_wire_mode == WM_THREE)); // [R1]
    assign o_shift_reg = sr_q;
    assign o_count = cnt_q;
    assign o_start_flag = start_flag_q;
    assign o_ovf_flag = ovf_flag_q;
    assign o_stop_flag = stop_flag_q;
    assign o_collision = col_q;
    assign o_ovf_pulse = ovf_pulse_q;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_n_q);

    AST_OVF_WRAP: assert property ( // [R23]
        cnt_wrap |=> ovf_flag_q && (cnt_q == 4'h0) && ovf_pulse_q)
        else $error("overflow flag not set on wrap");

    AST_CNT_EDGES: assert property ( // [R20]
        (i_clock_sel[1] && (scl_rise || scl_fall) && !i_cnt_wr)
        |=> cnt_q == $past(cnt_q) + 4'h1)
        else $error("external edge did not count");

    AST_SHIFT_RISE: assert property ( // [R10]
        (i_clock_sel == CS_EXT_POS && scl_rise && !i_sr_wr)
        |=> sr_q == {$past(sr_q[6:0]), $past(sda_q)})
        else $error("sda not shifted on rising scl");

    AST_START_SET: assert property ( // [R8]
        start_det |=> start_flag_q)
        else $error("start flag not set");

    AST_START_MODE: assert property ( // [R18]
        (start_det || stop_det) |-> two_wire)
        else $error("start detector active outside two-wire");

    AST_START_HOLD: assert property ( // [R9]
        (two_wire && start_flag_q && scl_fall && !i_clr_start) |=> !o_scl_oe_n [*2])
        else $error("scl not held after start");

    AST_HOLD_RELEASE: assert property ( // [R22]
        (start_hold_q && i_clr_start && !start_det) |=> !start_hold_q)
        else $error("clearing start flag did not release hold");

    AST_OVF_HOLD: assert property ( // [R11]
        (i_wire_mode == WM_TWO_HOLD && ovf_flag_q) |-> !o_scl_oe_n && !o_scl_out)
        else $error("scl not forced low on overflow");

    AST_STOP_SET: assert property ( // [R24]
        stop_det |=> stop_flag_q && !start_flag_q == $past(!start_flag_q && !start_det))
        else $error("stop flag not set");

    AST_SDA_DELAY: assert property ( // [R17]
        $past(rst_n_q, SDA_DLY) |-> sda_dly == $past(sda_q, SDA_DLY))
        else $error("sda delay line wrong length");

    AST_SDA_OPEN_DRAIN: assert property ( // [R7]
        two_wire |-> !o_sda_out && (o_sda_oe_n == !sda_low))
        else $error("sda driven high in two-wire mode");

    AST_LATCH_EDGE: assert property ( // [R4]
        (i_clock_sel == CS_EXT_POS && $past(i_clock_sel) == CS_EXT_POS
         && $changed(latch_q)) |-> $past(scl_fall || !scl_q))
        else $error("data output changed while scl high");

    CV_START: cover property (start_det ##[1:200] start_hold_q);
    CV_OVF: cover property (two_wire && cnt_wrap);
    CV_STOP: cover property (stop_det);
    CV_SPI: cover property (i_wire_mode == WM_THREE && cnt_wrap);
endmodule

// >>> ustws_pkg.sv
package ustws_pkg;
    localparam int CNT_W = 4;
    localparam int SR_W = 8;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [7:0] SR_RST = 8'h00;
    localparam int SR_MSB = 7;

    // wire mode field
    localparam logic [1:0] WM_OFF = 2'h0;
    localparam logic [1:0] WM_THREE = 2'h1;
    localparam logic [1:0] WM_TWO = 2'h2;
    localparam logic [1:0] WM_TWO_HOLD = 2'h3;

    // clock select field
    localparam logic [1:0] CS_SW = 2'h0;
    localparam logic [1:0] CS_T0 = 2'h1;
    localparam logic [1:0] CS_EXT_POS = 2'h2;
    localparam logic [1:0] CS_EXT_NEG = 2'h3;

    localparam int CLK_PERIOD_NS = 4;
    localparam int SDA_DLY_MIN_NS = 50;
    localparam int SDA_DLY_MAX_NS = 300;
    localparam int SDA_DLY_CYC = (SDA_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SDA_DLY_MAX_CYC = SDA_DLY_MAX_NS / CLK_PERIOD_NS;
endpackage

// >>> ustws_slave_fix.sv
// intentionally empty

// >>> ustws_tw_master.sv
module ustws_tw_master (
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_m,
    output logic o_sda_m
);
    timeunit 1ns;
    timeprecision 1ps;
    // released lines read high through the pull-ups
    initial begin
        o_scl_m = 1'b1;
        o_sda_m = 1'b1;
    end
    // slave may stretch, so wait for the line itself, bounded
    task automatic rise_scl();
        int n;
        n = 0;
        o_scl_m = 1'b1;
        while (i_scl !== 1'b1 && n < 2000) begin
            #4;
            n++;
        end
        #16;
    endtask
    task automatic park();
        o_scl_m = 1'b0;
    endtask
    // long high time so the delayed data edge still meets a high clock
    // in bit transfers data moves only while the clock is low, though the clock stays low for less than the slave's data delay
    task automatic start_cond();
        o_sda_m = 1'b1;
        #100;
        rise_scl();
        #80 o_sda_m = 1'b0;
        #100 o_scl_m = 1'b0;
        #16;
    endtask
    task automatic bit_xfer(input logic b, output logic seen);
        o_scl_m = 1'b0;
        o_sda_m = b;
        #16;
        rise_scl();
        seen = i_sda;
        o_scl_m = 1'b0;
        #16;
    endtask
    task automatic stop_cond();
        o_sda_m = 1'b0;
        #100;
        rise_scl();
        #100 o_sda_m = 1'b1;
        #100;
    endtask
endmodule

// >>> testbench.sv
module testbench;
    import ustws_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [1:0] wm = WM_OFF;
    logic [1:0] cs = CS_SW;
    logic stb = 1'b0, t0 = 1'b0, srw = 1'b0, cw = 1'b0, cst = 1'b0, cov = 1'b0, csp = 1'b0;
    logic [7:0] srd = 8'h00;
    logic [3:0] cd = 4'h0;
    logic sdir = 1'b0, cdir = 1'b1, ddir = 1'b1, sport = 1'b1, cport = 1'b1;
    logic scl_m, sda_m, sda_oe_n, sda_o, scl_oe_n, scl_o, ovf_p, st_f, ov_f, sp_f, seen;
    logic do_o, do_oe_n, col;
    logic [7:0] sr, b;
    logic [3:0] cnt;
    // open drain: any driver enabled with a low output pulls the line
    wire sda = sda_m & (sda_oe_n | sda_o);
    wire scl = scl_m & (scl_oe_n | scl_o);
    int fails = 0, n_tests = 0, seed = 90582, cyc = 0, pulses = 0, exp_sr, exp_cnt, wraps, p0;
    ustws_slave DUT (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_wire_mode(wm),
        .i_clock_sel(cs), .i_clk_strobe(stb), .i_t0_match(t0), .i_sr_wr(srw),
        .i_sr_wdata(srd), .i_cnt_wr(cw), .i_cnt_wdata(cd), .i_clr_start(cst),
        .i_clr_ovf(cov), .i_clr_stop(csp), .i_sda_port(sport), .i_sda_dir(sdir),
        .i_scl_port(cport), .i_scl_dir(cdir), .i_do_dir(ddir), .i_sda_in(sda),
        .i_scl_in(scl), .o_sda_out(sda_o), .o_sda_oe_n(sda_oe_n), .o_scl_out(scl_o),
        .o_scl_oe_n(scl_oe_n), .o_do_out(do_o), .o_do_oe_n(do_oe_n), .o_shift_reg(sr),
        .o_count(cnt), .o_start_flag(st_f), .o_ovf_flag(ov_f), .o_stop_flag(sp_f),
        .o_collision(col), .o_ovf_pulse(ovf_p));
    ustws_tw_master M (.i_scl(scl), .i_sda(sda), .o_scl_m(scl_m), .o_sda_m(sda_m));
    initial begin
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (ovf_p === 1'b1) pulses <= pulses + 1;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic sw(input logic [2:0] clr, input logic wc, input logic [3:0] c,
                      input logic ws, input logic [7:0] s);
        @(posedge i_sys_clk);
        {cst, cov, csp} <= clr;
        cw <= wc;
        cd <= c;
        srw <= ws;
        srd <= s;
        @(posedge i_sys_clk);
        {cst, cov, csp, cw, srw} <= 5'h00;
        // let a pin change from the write pass the slave's data delay first
        repeat (20) @(posedge i_sys_clk);
    endtask
    task automatic settle();
        repeat (40) @(posedge i_sys_clk);
    endtask
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) M.bit_xfer(v[i], seen);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        chk("rst_sr", sr, SR_RST);
        chk("rst_flags", {st_f, ov_f, sp_f, 1'b0, cnt}, 8'h00);
        exp_cnt = $random(seed) & 15;
        exp_sr = 8'h5A;
        wraps = 0;
        sw(3'b111, 1'b1, exp_cnt[3:0], 1'b1, 8'h5A);
        p0 = pulses;
        for (int k = 0; k < 20; k++) begin
            @(posedge i_sys_clk);
            stb <= 1'b1;
            @(posedge i_sys_clk);
            stb <= 1'b0;
            exp_sr = ((exp_sr << 1) | 1) & 255;
            exp_cnt = (exp_cnt + 1) & 15;
            if (exp_cnt == 0) wraps++;
            @(posedge i_sys_clk);
            #1;
            chk("count", {4'h0, cnt}, exp_cnt[7:0]);
            chk("shift", sr, exp_sr[7:0]);
        end
        repeat (3) @(posedge i_sys_clk);
        chk("ovf", {7'h00, ov_f}, 8'h01);
        chk("pulses", pulses - p0, wraps[7:0]);
        cs <= CS_T0;
        sw(3'b110, 1'b1, 4'hF, 1'b0, 8'h00);
        t0 <= 1'b1;
        @(posedge i_sys_clk);
        t0 <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        chk("t0_wrap", {st_f, ov_f, 2'h0, cnt}, 8'hC0);
        sw(3'b111, 1'b0, 4'h0, 1'b0, 8'h00);
        M.start_cond();
        settle();
        chk("start_off", {7'h00, st_f}, 8'h00);
        M.stop_cond();
        M.park();
        settle();
        @(posedge i_sys_clk);
        wm <= WM_THREE;
        cs <= CS_EXT_POS;
        sw(3'b111, 1'b1, 4'h0, 1'b1, 8'h00);
        b = $random(seed);
        send_byte(b);
        settle();
        chk("spi_data", sr, b);
        chk("spi_done", {ov_f, 3'h0, cnt}, 8'h80);
        chk("spi_do", {6'h00, do_oe_n, do_o}, {7'h00, b[7]});
        // the slave would pull data low from a zero msb, so load ones first
        sw(3'b111, 1'b0, 4'h0, 1'b1, 8'hFF);
        @(posedge i_sys_clk);
        wm <= WM_TWO_HOLD;
        sdir <= 1'b1;
        M.start_cond();
        settle();
        chk("start", {6'h00, sp_f, st_f}, 8'h01);
        chk("start_hold", {6'h00, scl_oe_n, scl_o}, 8'h00);
        sw(3'b100, 1'b1, 4'h0, 1'b0, 8'h00);
        settle();
        chk("hold_free", {7'h00, scl_oe_n}, 8'h01);
        b = $random(seed) & 8'hFE;
        send_byte(b);
        settle();
        chk("address", sr, b);
        chk("ovf_hold", {ov_f, scl_oe_n, 2'h0, cnt}, 8'h80);
        chk("collision", {7'h00, col}, {7'h00, b[7]});
        sw(3'b010, 1'b1, 4'hE, 1'b1, 8'h00);
        M.bit_xfer(1'b1, seen);
        chk("ack", {7'h00, seen}, 8'h00);
        settle();
        chk("ack_hold", {6'h00, ov_f, scl_oe_n}, 8'h02);
        sw(3'b010, 1'b1, 4'h0, 1'b1, 8'hFF);
        b = $random(seed);
        send_byte(b);
        settle();
        chk("data", sr, b);
        sw(3'b010, 1'b1, 4'hE, 1'b1, 8'hFF);
        M.bit_xfer(1'b1, seen);
        chk("nack", {7'h00, seen}, 8'h01);
        settle();
        sw(3'b010, 1'b1, 4'h0, 1'b1, 8'hFF);
        M.stop_cond();
        settle();
        chk("stop", {6'h00, st_f, sp_f}, 8'h01);
        sw(3'b001, 1'b0, 4'h0, 1'b0, 8'h00);
        chk("stop_clr", {7'h00, sp_f}, 8'h00);
        print_verdict();
    end
endmodule
